// [src/event_ctl_defines.vh]
`ifndef EVENT_CTL_DEFINES_VH
`define EVENT_CTL_DEFINES_VH
// priority levels, 0 highest
`define LVL_EMU 4'h0
`define LVL_RST 4'h1
`define LVL_NMI 4'h2
`define LVL_EXC 4'h3
`define LVL_HWE 4'h5
`define LVL_TMR 4'h6
`define LVL_GEN_FIRST 4'h7
`define LVL_SW_FIRST 4'hE
`define LVL_NONE 5'h10
// levels that no enable bit can hold back
`define LVL_FIXED_MASK 16'h000F
// levels that the router may reach
`define LVL_GEN_MASK 16'hFF80
// single level bit before shifting
`define LVL_ONE 16'h0001
// widths
`define NUM_LEVELS 16
`define NUM_SRC 8
`define NUM_GEN 9
`define MAP_W 4
`define MAP_BUS_W 32
`define ADDR_W 32
`define STATE_W 32
// default routing: source n to level 7+n, last source shares level 13
`define MAP_RESET 32'hDDCBA987
// stack
`define STACK_DEPTH 16
`define SP_W 5
`define SP_STEP 5'h01
`endif

// [src/two_stage_event_controller.v]
`timescale 1ns/1ns
// Notes on behaviour
// - a new higher event may start while older routines stay active, nested
// - among competing events the higher priority one is always dispatched first; an offered level is still taken before a higher one arriving later
// - five event classes: emulation, reset, nonmaskable, exception, interrupt
// - emulation event puts the core in emulation mode driven by debug port
// - a reset event resets the whole processor
// - nonmaskable event comes from watchdog expiry or the external pin
// - exceptions are synchronous; faulting instruction is held from completing
// - interrupts are asynchronous: timers, peripherals, pins, software raise
// - each level has its own return address and return instruction
// - every taken event pushes processor state onto the supervisor stack
// - peripheral requests pass the router, then the general levels of core stage
// - fixed ranking 0 highest: emu, reset, nmi, exc, hwerr 5, timer 6, 7 to 15
// - nine general levels; the two lowest kept for software raised interrupts
// - router resets to a default map; software may rewrite map and priorities
`include "event_ctl_defines.vh"
module two_stage_event_controller
(
	input wire mclk,
	input wire reset,
	input wire emu_req,
	input wire reset_req,
	input wire watchdog_expired,
	input wire nmi_pin,
	input wire exc_req,
	input wire hw_error_req,
	input wire core_timer_req,
	input wire [`NUM_SRC-1:0] periph_req,
	input wire [1:0] sw_raise,
	input wire map_wr,
	input wire [`MAP_BUS_W-1:0] map_wdata,
	input wire [`ADDR_W-1:0] cur_pc,
	input wire [`STATE_W-1:0] cur_state,
	input wire [`LVL_NONE-1:0] level_enable,
	input wire event_ack,
	input wire rtn_req,
	input wire [3:0] rtn_level,
	output reg event_valid,
	output reg [3:0] event_level,
	output reg [`ADDR_W-1:0] rtn_addr,
	output reg rtn_valid,
	output wire exc_stall,
	output reg emu_mode,
	output reg core_reset,
	output reg [`LVL_NONE-1:0] active_q,
	output reg [`LVL_NONE-1:0] pending_q,
	output reg [`MAP_BUS_W-1:0] map_q,
	output reg push_valid,
	output reg [`STATE_W-1:0] push_data,
	output reg stack_overflow
);
	// dispatch sequence: idle, offer until taken, push, then idle again
	// returns are only accepted in idle, so they never race a push
	localparam S_IDLE = 2'h0; // nothing offered
	localparam S_OFFER = 2'h1; // level shown, waiting for the core
	localparam S_PUSH = 2'h2; // state goes onto the stack
	// sequencer
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [3:0] sel_q;

	// return address per level and the supervisor stack
	reg [`ADDR_W-1:0] ret_reg [0:`NUM_LEVELS-1];
	reg [`STATE_W-1:0] stack_mem [0:`STACK_DEPTH-1];
	reg [`SP_W-1:0] sp_q;
	wire stack_room;
	wire [`SP_W-1:0] sp_top;

	// request vectors and the two winners
	reg [`LVL_NONE-1:0] raw_req;
	reg [`LVL_NONE-1:0] routed;
	reg [4:0] best_pend;
	reg [4:0] best_act;

	// strobes of the current cycle
	wire offer_now;
	wire take_now;
	wire push_now;
	wire rtn_now;
	integer i; // reset loop over the return registers
	integer r; // router loop over the sources

	// lowest index set bit, LVL_NONE when empty
	function [4:0] first_set;
		input [`LVL_NONE-1:0] v;
		integer k;
		begin
			first_set = `LVL_NONE;
			for (k = `NUM_LEVELS - 1; k >= 0; k = k - 1)
				if (v[k])
					first_set = k[4:0];
		end
	endfunction

	// one-hot bit of a level
	function [`LVL_NONE-1:0] level_bit;
		input [3:0] lvl;
		begin
			level_bit = `LVL_ONE << lvl;
		end
	endfunction

	// router: each peripheral source lands on its programmed general level
	// levels below the general range are cut off in the gather step
	always @*
	begin
		routed = {`LVL_NONE{1'b0}};
		for (r = 0; r < `NUM_SRC; r = r + 1)
			if (periph_req[r])
				routed[map_q[r*`MAP_W +: `MAP_W]] = 1'b1;
	end

	// gather every event class into the level vector
	// level four has no source and stays clear
	always @*
	begin
		raw_req = routed & `LVL_GEN_MASK;
		raw_req[`LVL_EMU] = emu_req;
		raw_req[`LVL_RST] = reset_req;
		raw_req[`LVL_NMI] = watchdog_expired | nmi_pin;
		raw_req[`LVL_EXC] = exc_req;
		raw_req[`LVL_HWE] = hw_error_req;
		raw_req[`LVL_TMR] = core_timer_req;
		raw_req[`LVL_SW_FIRST] = raw_req[`LVL_SW_FIRST] | sw_raise[0];
		raw_req[`LVL_SW_FIRST+4'h1] = raw_req[`LVL_SW_FIRST+4'h1] | sw_raise[1];
	end

	// highest pending and highest active
	always @*
	begin
		best_pend = first_set(pending_q & (level_enable | `LVL_FIXED_MASK));
		best_act = first_set(active_q);
	end

	// faulting instruction held until exception is dispatched
	assign exc_stall = pending_q[`LVL_EXC] | exc_req;

	// dispatch sequencing
	always @*
	begin
		state_d = state_q;
		case (state_q)
			S_IDLE:
				// only a strictly higher level may preempt
				if (best_pend < best_act && best_pend != `LVL_NONE)
					state_d = S_OFFER;
			S_OFFER:
				if (event_ack)
					state_d = S_PUSH;
			S_PUSH:
				state_d = S_IDLE;
			default:
				state_d = S_IDLE;
		endcase
	end

	// handshake strobes of this cycle
	assign offer_now = (state_q == S_IDLE) && (state_d == S_OFFER);
	assign take_now = (state_q == S_OFFER) && event_ack;
	assign push_now = (state_q == S_PUSH);

	// a return is only honoured in idle and for a level that is active
	assign rtn_now = rtn_req && (state_q == S_IDLE) && active_q[rtn_level];

	// room left on the stack, and the slot of the newest entry
	assign stack_room = (sp_q < `STACK_DEPTH);
	assign sp_top = sp_q - `SP_STEP;

	// dispatch state; the offer stands until the core takes it
	// the level is frozen once offered; a higher one nests right after
	always @(posedge mclk)
	begin
		if (reset)
		begin
			state_q <= S_IDLE;
			sel_q <= 4'h0;
			event_valid <= 1'b0;
			event_level <= 4'h0;
		end
		else
		begin
			state_q <= state_d;
			if (offer_now)
			begin
				sel_q <= best_pend[3:0];
				event_level <= best_pend[3:0];
				event_valid <= 1'b1;
			end
			else if (state_q != S_OFFER || event_ack)
				event_valid <= 1'b0;
		end
	end

	// pending set: requests are sticky, a taken level is cleared, a new request wins
	// masking by level_enable happens at dispatch, not here
	always @(posedge mclk)
	begin
		if (reset)
			pending_q <= {`LVL_NONE{1'b0}};
		else if (take_now)
			pending_q <= (pending_q & ~level_bit(sel_q)) | raw_req;
		else
			pending_q <= pending_q | raw_req;
	end

	// nesting: a taken level turns active, its return releases it
	always @(posedge mclk)
	begin
		if (reset)
			active_q <= {`LVL_NONE{1'b0}};
		else if (take_now)
			active_q <= active_q | level_bit(sel_q);
		else if (rtn_now)
			active_q <= active_q & ~level_bit(rtn_level);
	end

	// one return address per level, caught when the core takes the event
	always @(posedge mclk)
	begin
		if (reset)
		begin
			for (i = 0; i < `NUM_LEVELS; i = i + 1)
				ret_reg[i] <= {`ADDR_W{1'b0}};
		end
		else if (take_now)
			ret_reg[sel_q] <= cur_pc;
	end

	// return: saved address handed back with a one cycle strobe
	// the stack pops in the same cycle, in the stack process
	always @(posedge mclk)
	begin
		if (reset)
		begin
			rtn_valid <= 1'b0;
			rtn_addr <= {`ADDR_W{1'b0}};
		end
		else
		begin
			rtn_valid <= rtn_now;
			if (rtn_now)
				rtn_addr <= ret_reg[rtn_level];
		end
	end

	// emulation mode lasts until its own return; reset is a single pulse
	always @(posedge mclk)
	begin
		if (reset)
		begin
			emu_mode <= 1'b0;
			core_reset <= 1'b0;
		end
		else
		begin
			core_reset <= take_now && (sel_q == `LVL_RST);
			if (take_now && sel_q == `LVL_EMU)
				emu_mode <= 1'b1;
			else if (rtn_now && rtn_level == `LVL_EMU)
				emu_mode <= 1'b0;
		end
	end

	// supervisor stack: state pushed one cycle after the take, popped on return
	// at most fifteen levels can nest, so overflow only guards against misuse
	always @(posedge mclk)
	begin
		if (reset)
		begin
			sp_q <= {`SP_W{1'b0}};
			push_valid <= 1'b0;
			push_data <= {`STATE_W{1'b0}};
			stack_overflow <= 1'b0;
		end
		else
		begin
			push_valid <= push_now && stack_room;
			if (push_now && stack_room)
			begin
				stack_mem[sp_q[3:0]] <= cur_state;
				sp_q <= sp_q + `SP_STEP;
				push_data <= cur_state;
			end
			else if (push_now)
				stack_overflow <= 1'b1; // sticky, no room left
			else if (rtn_now && sp_q != {`SP_W{1'b0}})
			begin
				sp_q <= sp_top;
				push_data <= stack_mem[sp_top[3:0]];
			end
		end
	end

	// router map: default after reset, rewritten by software
	// nibble n of the map holds the level of source n
	always @(posedge mclk)
	begin
		if (reset)
			map_q <= `MAP_RESET;
		else if (map_wr)
			map_q <= map_wdata;
	end
endmodule // two_stage_event_controller

// [dv/evt_sva.sv]
`timescale 1ns/1ns
module event_rules_sva
(
	input wire mclk,
	input wire reset,
	input wire nmi_pin,
	input wire watchdog_expired,
	input wire event_valid,
	input wire event_ack,
	input wire [3:0] event_level,
	input wire rtn_valid,
	input wire exc_stall,
	input wire emu_mode,
	input wire core_reset,
	input wire push_valid,
	input wire [15:0] active_q,
	input wire [15:0] pending_q
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// nonmaskable sources reach the pending set
	chk_nmi_pin_seen: assert property (nmi_pin |=> pending_q[2] | active_q[2])
		else $error("nmi pin lost");
	chk_wdog_seen: assert property (watchdog_expired |=> pending_q[2] | active_q[2])
		else $error("watchdog lost");
	// offer handshake, push and nesting order
	chk_offer_hold: assert property (event_valid & !event_ack |=> event_valid)
		else $error("offer dropped");
	chk_push_after: assert property (event_valid & event_ack |-> ##2 push_valid)
		else $error("no push");
	chk_nest_order: assert property (
		event_valid |-> !(active_q & ((16'h2 << event_level) - 16'h1))) else $error("bad nest");
	chk_emu_enter: assert property (
		event_valid & event_ack & event_level == 4'h0 |-> ##[1:3] emu_mode) else $error("no emu");
	chk_reset_pulse: assert property (core_reset |=> !core_reset)
		else $error("reset pulse long");
	chk_rtn_pulse: assert property (rtn_valid |=> !rtn_valid)
		else $error("return pulse long");
	// the stall may only end when the exception itself is taken
	chk_exc_stall: assert property (
		exc_stall & !(event_valid & event_ack & event_level == 4'h3) |=> exc_stall)
		else $error("stall dropped early");
endmodule // event_rules_sva

// [dv/core_model.sv]
`timescale 1ns/1ns
// core side: accepts an offer after lag cycles, one cycle of ack
module core_model
(
	input wire mclk,
	input wire event_valid,
	input wire [3:0] lag,
	output reg event_ack
);
	integer n = 0;
	initial event_ack = 1'b0;
	always @(posedge mclk)
	begin
		#1;
		n = (event_valid && !event_ack) ? n + 1 : 0;
		event_ack = event_valid && !event_ack && n > lag;
	end
endmodule // core_model

// [dv/tb_top.sv]
`timescale 1ns/1ns
`include "event_ctl_defines.vh"
module tb_top;
	reg mclk, reset, map_wr, rtn_req;
	reg [6:0] rq;
	reg [7:0] periph_req;
	reg [1:0] sw_raise;
	reg [31:0] map_wdata, cur_pc;
	reg [3:0] rtn_level, lag;
	reg [15:0] lvl_en;
	wire event_ack, event_valid, rtn_valid, exc_stall, emu_mode, core_reset, push_valid, ovf;
	wire [3:0] event_level;
	wire [31:0] rtn_addr, map_q, push_data;
	wire [15:0] active_q, pending_q;
	integer n_fail = 0, n_compared = 0, i;
	two_stage_event_controller i_dut (.mclk, .reset, .emu_req(rq[0]), .reset_req(rq[1]),
		.nmi_pin(rq[2]), .exc_req(rq[3]), .hw_error_req(rq[4]), .core_timer_req(rq[5]),
		.watchdog_expired(rq[6]), .periph_req, .sw_raise, .map_wr, .map_wdata, .cur_pc,
		.cur_state(32'h5A5A0001), .level_enable(lvl_en), .event_ack, .rtn_req, .rtn_level,
		.event_valid, .event_level, .rtn_addr, .rtn_valid, .exc_stall, .emu_mode, .core_reset,
		.active_q, .pending_q, .map_q, .push_valid, .push_data, .stack_overflow(ovf));
	core_model i_core (.mclk, .event_valid, .lag, .event_ack);
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task tick;
	begin
		@(posedge mclk);
		#1;
	end
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
	begin
		n_compared = n_compared + 1;
		if (seen !== exp)
		begin
			n_fail = n_fail + 1;
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
		end
	end
	endtask
	task end_sim;
	begin
		if (n_fail == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask
	task req(input [6:0] m, input [7:0] p, input [1:0] s);
	begin
		{rq, periph_req, sw_raise} = {m, p, s};
		tick;
		{rq, periph_req, sw_raise} = 17'h0;
	end
	endtask
	// wait for offer, check level and pushed state
	task take(input [3:0] l);
	begin
		cur_pc = 32'h00001000 + l;
		for (i = 0; i < 30 && event_valid !== 1'b1; i = i + 1)
			tick;
		chk(event_level, l);
		for (i = 0; i < 30 && push_valid !== 1'b1; i = i + 1)
			tick;
		chk(push_data, 32'h5A5A0001);
	end
	endtask
	task ret(input [3:0] l);
	begin
		repeat (2) tick;
		{rtn_level, rtn_req} = {l, 1'b1};
		tick;
		rtn_req = 1'b0;
		for (i = 0; i < 30 && rtn_valid !== 1'b1; i = i + 1)
			tick;
		chk(rtn_addr, 32'h00001000 + l);
	end
	endtask
	task s_nmi;
	begin
		req(7'h04, 8'h0, 2'h0);
		take(4'h2);
		ret(4'h2);
		// watchdog path with every enable off: still nonmaskable
		lvl_en = 16'h0000;
		req(7'h40, 8'h0, 2'h0);
		take(4'h2);
		ret(4'h2);
		lvl_en = 16'hFFFF;
	end
	endtask
	task s_nest;
	begin
		req(7'h0, 8'h01, 2'h0);
		take(4'h7);
		req(7'h20, 8'h0, 2'h0);
		take(4'h6);
		chk(active_q[7:6], 2'h3);
		ret(4'h6);
		ret(4'h7);
	end
	endtask
	task s_prio;
	begin
		req(7'h10, 8'h0, 2'h2);
		take(4'h5);
		chk(pending_q[15], 1'b1);
		ret(4'h5);
		take(4'hF);
		ret(4'hF);
	end
	endtask
	task s_map;
	begin
		{map_wr, map_wdata} = {1'b1, 32'hDDCBA98C};
		tick;
		map_wr = 1'b0;
		chk(map_q, 32'hDDCBA98C);
		req(7'h0, 8'h01, 2'h0);
		take(4'hC);
		ret(4'hC);
	end
	endtask
	task s_core;
	begin
		req(7'h08, 8'h0, 2'h0);
		chk(exc_stall, 1'b1);
		take(4'h3);
		ret(4'h3);
		req(7'h01, 8'h0, 2'h0);
		take(4'h0);
		chk(emu_mode, 1'b1);
		ret(4'h0);
		chk(emu_mode, 1'b0);
		req(7'h02, 8'h0, 2'h0);
		for (i = 0; i < 30 && core_reset !== 1'b1; i = i + 1)
			tick;
		chk(core_reset, 1'b1);
		chk(ovf, 1'b0);
	end
	endtask
	initial
	begin
		{reset, rq, periph_req, sw_raise, map_wr, map_wdata, rtn_req} = {1'b1, 51'h0};
		{cur_pc, rtn_level, lag} = 40'h3;
		lvl_en = 16'hFFFF;
		repeat (12) @(posedge mclk);
		#1 reset = 1'b0;
		chk(map_q, `MAP_RESET);
		s_nmi;
		lag = 4'h0;
		s_nest;
		s_prio;
		s_map;
		s_core;
		end_sim;
	end
	// watchdog against a hang
	initial
	begin
		#300000;
		n_fail = n_fail + 1;
		end_sim;
	end
endmodule // tb_top
bind two_stage_event_controller event_rules_sva i_chk (.mclk, .reset, .nmi_pin, .watchdog_expired,
	.event_valid, .event_ack, .event_level, .rtn_valid, .exc_stall, .emu_mode, .core_reset,
	.push_valid, .active_q, .pending_q);
